//--- design/async_serial_port_autobaud.v
// Serial port with shift, eight-bit and nine-bit modes and baud measurement
//
// Decided for this implementation: the plain strobed port.
`include "serial_consts.vh"

module async_serial_port_autobaud #(
    parameter DIV_W = 14
) (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Register port
    input wire [31:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata_q,
    // Serial pins
    output reg txd_q,
    input wire rxd_i,
    output reg rxd_o_q,
    output reg rxd_oe_q,
    // Receive lines watched by the baud measurement
    input wire [3:0] meter_rx,
    // Interrupt requests
    output reg tx_irq_q,
    output reg rx_irq_q
);

    localparam T_IDLE = 5'b00001;
    localparam T_START = 5'b00010;
    localparam T_DATA = 5'b00100;
    localparam T_STOP = 5'b01000;
    localparam T_SHIFT = 5'b10000;
    localparam R_IDLE = 4'b0001;
    localparam R_START = 4'b0010;
    localparam R_DATA = 4'b0100;
    localparam R_STOP = 4'b1000;

    // Register state
    reg tx_ie_q;
    reg rx_ie_q;
    reg [DIV_W-1:0] div_q;
    reg [1:0] mode_q;
    reg mpe_q;
    reg ren_q;
    reg tb8_q;
    reg rb8_q;
    reg ti_q;
    reg ri_q;
    reg [7:0] rx_byte_q;
    reg adapt_run_q;
    reg adapt_on_q;
    reg [1:0] rx_sel_q;

    // Engines
    reg [4:0] tst_q;
    reg [3:0] tsub_q;
    reg [3:0] tbit_q;
    reg [8:0] tshf_q;
    reg m0rx_q;
    reg [3:0] rst_q;
    reg [3:0] rsub_q;
    reg [3:0] rbit_q;
    reg [8:0] rshf_q;
    reg rxs1_q;
    reg rxs2_q;
    reg rxprev_q;

    reg ti_set;
    reg ri_set;
    reg rb8_set;
    reg [7:0] rx_byte_d;
    reg rb8_d;

    wire tick;
    wire meter_done;
    wire [DIV_W-1:0] meter_res;
    wire wr_ctl = wr && addr == `LINE_CONTROL_OFS;
    wire wr_dat = wr && addr == `TX_RX_BYTE_OFS;
    wire wr_cfg = wr && addr == `BAUD_ADAPT_CONFIG_OFS;
    wire shift_mode = mode_q == `MODE_SHIFT;
    wire nine = !shift_mode && mode_q != `MODE_EIGHT;
    wire [3:0] last_bit = nine ? 4'h8 : 4'h7;
    wire busy = tst_q != T_IDLE;
    wire meter_start = wr_cfg && wdata[`CFG_START_BIT] && wdata[`CFG_ENABLE_BIT]
        && !adapt_run_q;
    wire meter_abort = adapt_run_q && wr_cfg
        && !(wdata[`CFG_START_BIT] && wdata[`CFG_ENABLE_BIT]);

    baud_gen #(
        .DIV_W(DIV_W)
    ) u_baud (
        .mclk(mclk),
        .rst_b(rst_b),
        .divisor(div_q),
        .tick_q(tick)
    );

    autobaud_meter #(
        .RES_W(DIV_W)
    ) u_meter (
        .mclk(mclk),
        .rst_b(rst_b),
        .meter_rx(meter_rx),
        .line_sel(rx_sel_q),
        .start(meter_start),
        .abort(meter_abort),
        .done_q(meter_done),
        .result_q(meter_res)
    );

    // Transmit engine; in shift mode it also clocks reception
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tst_q <= T_IDLE;
            tsub_q <= 4'h0;
            tbit_q <= 4'h0;
            tshf_q <= 9'h000;
            m0rx_q <= 1'b0;
            txd_q <= 1'b1;
            rxd_o_q <= 1'b1;
            rxd_oe_q <= 1'b0;
        end
        else
        begin
            case (tst_q)
                T_IDLE:
                begin
                    txd_q <= 1'b1;
                    rxd_oe_q <= 1'b0;
                    tsub_q <= 4'h0;
                    tbit_q <= 4'h0;
                    if (wr_dat)
                    begin
                        tshf_q <= {tb8_q, wdata[7:0]};
                        m0rx_q <= 1'b0;
                        if (shift_mode)
                        begin
                            tst_q <= T_SHIFT;
                            txd_q <= 1'b0;
                            rxd_o_q <= wdata[0];
                            rxd_oe_q <= 1'b1;
                        end
                        else
                        begin
                            tst_q <= T_START;
                            txd_q <= 1'b0;
                        end
                    end
                    else if (shift_mode && ren_q && !ri_q)
                    begin
                        tst_q <= T_SHIFT;
                        m0rx_q <= 1'b1;
                        txd_q <= 1'b0;
                    end
                end
                T_SHIFT:
                begin
                    tsub_q <= tsub_q + 4'h1;
                    // Clock low for six cycles, high for six: mclk over twelve
                    if (tsub_q == `SHIFT_CLK_HALF)
                    begin
                        txd_q <= 1'b1;
                        if (m0rx_q)
                            tshf_q[7:0] <= {rxs2_q, tshf_q[7:1]};
                    end
                    if (tsub_q == `SHIFT_CLK_LAST)
                    begin
                        tsub_q <= 4'h0;
                        tbit_q <= tbit_q + 4'h1;
                        if (!m0rx_q)
                            tshf_q[7:0] <= {1'b0, tshf_q[7:1]};
                        rxd_o_q <= tshf_q[1];
                        if (tbit_q == 4'h7)
                        begin
                            tst_q <= T_IDLE;
                            txd_q <= 1'b1;
                            rxd_oe_q <= 1'b0;
                        end
                        else
                            txd_q <= 1'b0;
                    end
                end
                T_START, T_DATA, T_STOP:
                begin
                    if (tick)
                    begin
                        tsub_q <= tsub_q + 4'h1;
                        if (tsub_q == `OVERSAMPLE)
                        begin
                            if (tst_q == T_START)
                            begin
                                tst_q <= T_DATA;
                                txd_q <= tshf_q[0];
                            end
                            else if (tst_q == T_DATA)
                            begin
                                tshf_q <= {1'b0, tshf_q[8:1]};
                                tbit_q <= tbit_q + 4'h1;
                                if (tbit_q == last_bit)
                                begin
                                    tst_q <= T_STOP;
                                    txd_q <= 1'b1;
                                end
                                else
                                    txd_q <= tshf_q[1];
                            end
                            else
                                tst_q <= T_IDLE;
                        end
                    end
                end
                default:
                    tst_q <= T_IDLE;
            endcase
        end
    end

    // Receive engine for framed modes
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxs1_q <= 1'b1;
            rxs2_q <= 1'b1;
            rxprev_q <= 1'b1;
            rst_q <= R_IDLE;
            rsub_q <= 4'h0;
            rbit_q <= 4'h0;
            rshf_q <= 9'h000;
        end
        else
        begin
            rxs1_q <= rxd_i;
            rxs2_q <= rxs1_q;
            rxprev_q <= rxs2_q;
            if (!ren_q || shift_mode)
                rst_q <= R_IDLE;
            else
            begin
                case (rst_q)
                    R_IDLE:
                    begin
                        rsub_q <= 4'h0;
                        rbit_q <= 4'h0;
                        if (rxprev_q && !rxs2_q)
                            rst_q <= R_START;
                    end
                    R_START, R_DATA, R_STOP:
                    begin
                        if (tick)
                        begin
                            rsub_q <= rsub_q + 4'h1;
                            // A start bit gone high by mid bit was a glitch
                            if (rst_q == R_START && rsub_q == `OVERSAMPLE_HALF)
                            begin
                                rsub_q <= 4'h0;
                                rst_q <= rxs2_q ? R_IDLE : R_DATA;
                            end
                            else if (rst_q == R_DATA && rsub_q == `OVERSAMPLE)
                            begin
                                rshf_q <= {rxs2_q, rshf_q[8:1]};
                                rbit_q <= rbit_q + 4'h1;
                                if (rbit_q == last_bit)
                                    rst_q <= R_STOP;
                            end
                            else if (rst_q == R_STOP && rsub_q == `OVERSAMPLE)
                                rst_q <= R_IDLE;
                        end
                    end
                    default:
                        rst_q <= R_IDLE;
                endcase
            end
        end
    end

    // Hardware events for the flags
    always @*
    begin
        ti_set = 1'b0;
        ri_set = 1'b0;
        rb8_set = 1'b0;
        rx_byte_d = nine ? rshf_q[7:0] : rshf_q[8:1];
        rb8_d = rshf_q[8];
        if (tst_q == T_SHIFT && tsub_q == `SHIFT_CLK_LAST && tbit_q == 4'h7)
        begin
            ti_set = !m0rx_q;
            ri_set = m0rx_q;
            rx_byte_d = tshf_q[7:0];
        end
        if (tst_q == T_DATA && tick && tsub_q == `OVERSAMPLE && tbit_q == last_bit)
            ti_set = 1'b1;
        if (rst_q == R_STOP && ren_q && !shift_mode && tick && rsub_q == `OVERSAMPLE)
        begin
            // Address filter: nine-bit data frames dropped while multiprocessor mode is on
            ri_set = rxs2_q && !(mpe_q && nine && !rshf_q[8]);
            rb8_set = ri_set && nine;
        end
    end

    // Register file
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_ie_q <= 1'b0;
            rx_ie_q <= 1'b0;
            div_q <= `RESET_DIVISOR;
            mode_q <= `MODE_SHIFT;
            mpe_q <= 1'b0;
            ren_q <= 1'b0;
            tb8_q <= 1'b0;
            rb8_q <= 1'b0;
            ti_q <= 1'b0;
            ri_q <= 1'b0;
            rx_byte_q <= 8'h00;
            adapt_run_q <= 1'b0;
            adapt_on_q <= 1'b0;
            rx_sel_q <= 2'h0;
            rdata_q <= 32'h0000_0000;
            tx_irq_q <= 1'b0;
            rx_irq_q <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
            begin
                tx_ie_q <= wdata[`CTL_TX_IE_BIT];
                rx_ie_q <= wdata[`CTL_RX_IE_BIT];
                div_q <= wdata[`CTL_DIV_MSB:`CTL_DIV_LSB];
                mode_q <= wdata[`CTL_MODE_MSB:`CTL_MODE_LSB];
                mpe_q <= wdata[`CTL_MPE_BIT];
                ren_q <= wdata[`CTL_REN_BIT];
                tb8_q <= wdata[`CTL_TB8_BIT];
            end
            // Set wins over a clearing write in the same cycle
            if (rb8_set)
                rb8_q <= rb8_d;
            else if (wr_ctl)
                rb8_q <= wdata[`CTL_RB8_BIT];
            if (ti_set)
                ti_q <= 1'b1;
            else if (wr_ctl)
                ti_q <= wdata[`CTL_TI_BIT];
            if (ri_set)
            begin
                ri_q <= 1'b1;
                rx_byte_q <= rx_byte_d;
            end
            else if (wr_ctl)
                ri_q <= wdata[`CTL_RI_BIT];
            if (wr_cfg)
            begin
                adapt_on_q <= wdata[`CFG_ENABLE_BIT];
                rx_sel_q <= wdata[`CFG_SEL_MSB:`CFG_SEL_LSB];
            end
            if (meter_done)
                adapt_run_q <= 1'b0;
            else if (wr_cfg)
                adapt_run_q <= wdata[`CFG_START_BIT] && wdata[`CFG_ENABLE_BIT];
            tx_irq_q <= ti_q && tx_ie_q;
            rx_irq_q <= ri_q && rx_ie_q;
            rdata_q <= 32'h0000_0000;
            if (rd)
            begin
                case (addr)
                    `LINE_CONTROL_OFS:
                        rdata_q <= {6'h00, tx_ie_q, rx_ie_q, busy, 1'b0, div_q,
                            mode_q, mpe_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
                    `TX_RX_BYTE_OFS:
                        rdata_q <= {24'h00_0000, rx_byte_q};
                    `BAUD_ADAPT_CONFIG_OFS:
                        rdata_q <= {23'h00_0000, adapt_run_q, 1'b0, adapt_on_q, 3'h0,
                            rx_sel_q, 1'b0};
                    `BAUD_ADAPT_RESULT_OFS:
                        rdata_q <= {18'h0_0000, meter_res};
                    default:
                        rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

//--- design/autobaud_meter.v
// Times one low pulse on a selected receive line to yield a divisor
`include "serial_consts.vh"

module autobaud_meter #(
    parameter RES_W = 14
) (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Receive lines of the four ports, asynchronous
    input wire [3:0] meter_rx,
    input wire [1:0] line_sel,
    // Control
    input wire start,
    input wire abort,
    // Outcome
    output reg done_q,
    output reg [RES_W-1:0] result_q
);

    localparam M_IDLE = 4'b0001;
    localparam M_WAIT_HIGH = 4'b0010;
    localparam M_WAIT_LOW = 4'b0100;
    localparam M_COUNT = 4'b1000;

    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    reg [3:0] state_q;
    reg [RES_W-1:0] cnt_q;
    wire line;

    assign line = sync2_q[line_sel];

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_q <= 4'hf;
            sync2_q <= 4'hf;
            state_q <= M_IDLE;
            cnt_q <= {RES_W{1'b0}};
            done_q <= 1'b0;
            result_q <= {RES_W{1'b0}};
        end
        else
        begin
            sync1_q <= meter_rx;
            sync2_q <= sync1_q;
            done_q <= 1'b0;
            if (abort)
                state_q <= M_IDLE;
            else
            begin
                case (state_q)
                    M_IDLE:
                    begin
                        if (start)
                            state_q <= M_WAIT_HIGH;
                    end
                    // Never time a pulse that was already under way
                    M_WAIT_HIGH:
                    begin
                        if (line)
                            state_q <= M_WAIT_LOW;
                    end
                    M_WAIT_LOW:
                    begin
                        cnt_q <= {{(RES_W-1){1'b0}}, 1'b1};
                        if (!line)
                            state_q <= M_COUNT;
                    end
                    M_COUNT:
                    begin
                        if (line)
                        begin
                            result_q <= cnt_q;
                            done_q <= 1'b1;
                            state_q <= M_IDLE;
                        end
                        else if (cnt_q != {RES_W{1'b1}})
                            cnt_q <= cnt_q + {{(RES_W-1){1'b0}}, 1'b1};
                    end
                    default:
                        state_q <= M_IDLE;
                endcase
            end
        end
    end

endmodule

//--- design/baud_gen.v
// Fractional divider giving the sixteen-times oversampling tick
`include "serial_consts.vh"

module baud_gen #(
    parameter DIV_W = 14
) (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Divisor in sixteenths of a clock
    input wire [DIV_W-1:0] divisor,
    // Oversampling tick
    output reg tick_q
);

    reg [DIV_W:0] acc_q;
    reg [DIV_W:0] acc_d;
    reg [DIV_W:0] div_eff;
    reg [DIV_W:0] sum;
    reg tick_d;

    // Divisors below one clock would let the accumulator run away
    always @*
    begin
        div_eff = {1'b0, divisor};
        if (div_eff < `OVERSAMPLE_STEP)
            div_eff = `OVERSAMPLE_STEP;
        sum = acc_q + `OVERSAMPLE_STEP;
        acc_d = sum;
        tick_d = 1'b0;
        if (divisor != `RESET_DIVISOR && sum >= div_eff)
        begin
            acc_d = sum - div_eff;
            tick_d = 1'b1;
        end
        if (divisor == `RESET_DIVISOR)
            acc_d = {(DIV_W+1){1'b0}};
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_q <= {(DIV_W+1){1'b0}};
            tick_q <= 1'b0;
        end
        else
        begin
            acc_q <= acc_d;
            tick_q <= tick_d;
        end
    end

endmodule

//--- shared/serial_consts.vh
// Register map, field positions and timing counts for the serial port
// Notes on behaviour
// - Bit rate is mclk over sixteen times a 14-bit divisor: 10 integer, 4 fraction bits.
// - Mode field: 00 shift register at mclk/12, 01 eight-bit, 10/11 nine-bit frames.
// - Control bit 5 enables multiprocessor filtering on the ninth received bit.
// - Control bit 4 enables the receiver; zero disables it.
// - Nine-bit modes send control bit 3 as the ninth data bit.
// - Nine-bit modes load control bit 2 with the ninth received bit.
// - Transmit flag bit 1 set at end of bit 8 (mode 0) or stop start.
// - Receive flag bit 0 set at end of bit 8 (mode 0) or mid stop.
// - Control bit 25 gates the transmit interrupt request.
// - Control bit 24 gates the receive interrupt request.
// - Control bit 23 reads one while a transmission is in progress.
// - Writing the data byte starts transmission; reading returns the last received byte.
// - Adaptation start bit 8 begins measurement; hardware clears it when finished.
// - Adaptation times a low pulse on the selected line and yields a divisor.
// - Configuration bit 6 switches the adaptation function on.
// - Selector bits 2:1 choose which of four receive lines is measured.
// - A finished measurement is held in a read-only 14-bit result field.
`ifndef SERIAL_CONSTS_VH
`define SERIAL_CONSTS_VH

`define LINE_CONTROL_OFS 32'h0000_0000
`define TX_RX_BYTE_OFS 32'h0000_0004
`define BAUD_ADAPT_CONFIG_OFS 32'h3000_0380
`define BAUD_ADAPT_RESULT_OFS 32'h3000_0384

`define CTL_TX_IE_BIT 25
`define CTL_RX_IE_BIT 24
`define CTL_BUSY_BIT 23
`define CTL_DIV_LSB 8
`define CTL_DIV_MSB 21
`define CTL_MODE_LSB 6
`define CTL_MODE_MSB 7
`define CTL_MPE_BIT 5
`define CTL_REN_BIT 4
`define CTL_TB8_BIT 3
`define CTL_RB8_BIT 2
`define CTL_TI_BIT 1
`define CTL_RI_BIT 0

`define CFG_START_BIT 8
`define CFG_ENABLE_BIT 6
`define CFG_SEL_LSB 1
`define CFG_SEL_MSB 2

`define MODE_SHIFT 2'h0
`define MODE_EIGHT 2'h1

`define RESET_DIVISOR 14'h0000
`define OVERSAMPLE 4'hf
`define OVERSAMPLE_HALF 4'h7
`define OVERSAMPLE_STEP 15'h0010
`define SHIFT_CLK_LAST 4'hb
`define SHIFT_CLK_HALF 4'h5

`endif

//--- test/serial_peer.sv
// Far-side device on the line pins and the measured receive lines
module serial_peer #(
    parameter int BIT = 16
) (
    // Clock
    input logic mclk,
    // Line pins
    input logic txd,
    output logic rxd,
    // Measured receive lines
    output logic [3:0] meter
);
    timeunit 1ns / 1ns;
    initial
    begin
        rxd = 1'b1;
        meter = 4'hf;
    end
    // Low start, data LSB first, high stop, then idle high
    task automatic send(input int n, input logic [8:0] v);
        rxd <= 1'b0;
        repeat (BIT) @(posedge mclk);
        for (int i = 0; i < n; i++)
        begin
            rxd <= v[i];
            repeat (BIT) @(posedge mclk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge mclk);
    endtask
    // Mid-bit sampling; a missing start bit yields all ones
    task automatic grab(input int n, output logic [8:0] v);
        int k;
        v = '0;
        for (k = 0; k < 300 && txd !== 1'b0; k++)
            @(negedge mclk);
        repeat (BIT / 2) @(negedge mclk);
        for (k = 0; k < n; k++)
        begin
            repeat (BIT) @(negedge mclk);
            v[k] = txd;
        end
    endtask
    // Low interval exactly as long as asked
    task automatic pulse(input int ln, input int len);
        meter[ln] <= 1'b0;
        repeat (len) @(posedge mclk);
        meter[ln] <= 1'b1;
    endtask
endmodule

//--- test/serial_port_properties.sv
// Port-level timing checks for the serial port
module serial_port_properties (
    // Clock and reset
    input logic mclk,
    input logic rst_b,
    // Register port
    input logic [31:0] addr,
    input logic [31:0] wdata,
    input logic wr,
    input logic rd,
    input logic [31:0] rdata_q,
    // Pins
    input logic txd_q,
    input logic rxd_oe_q,
    input logic tx_irq_q,
    input logic rx_irq_q
);
    timeunit 1ns / 1ns;
    logic [1:0] mode_q;
    logic [13:0] div_q;
    logic [7:0] gap_q;
    logic ctl_wr;
    logic go;
    assign ctl_wr = wr && addr == 32'h0;
    // Data write onto an idle framed line ticking every clock
    assign go = wr && addr == 32'h4 && mode_q != 2'h0 && div_q == 14'h0010 && gap_q == 8'hff;
    // Gap saturates past the longest frame, so go means the line is idle
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_q <= 2'h0;
            div_q <= 14'h0;
            gap_q <= 8'hff;
        end
        else
        begin
            if (ctl_wr)
            begin
                mode_q <= wdata[7:6];
                div_q <= wdata[21:8];
            end
            gap_q <= (wr && addr == 32'h4) ? 8'h0 : gap_q + {7'h0, ~&gap_q};
        end
    end
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    property p_rd_quiet;
        !$past(rd) |-> rdata_q == 32'h0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray read data");
    property p_result_hi;
        rd && addr == 32'h3000_0384 |=> rdata_q[31:14] == 18'h0;
    endproperty
    a_result_hi: assert property (p_result_hi) else $error("result too wide");
    property p_txie_off;
        ctl_wr && !wdata[25] |-> ##2 !tx_irq_q;
    endproperty
    a_txie_off: assert property (p_txie_off) else $error("tx irq not gated");
    property p_rxie_off;
        ctl_wr && !wdata[24] |-> ##2 !rx_irq_q;
    endproperty
    a_rxie_off: assert property (p_rxie_off) else $error("rx irq not gated");
    property p_tx_start;
        go |-> ##2 !txd_q [*8];
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("no start bit");
    property p_stop8;
        go && mode_q == 2'h1 |-> ##147 txd_q [*8];
    endproperty
    a_stop8: assert property (p_stop8) else $error("no stop bit");
    property p_shift_clk;
        mode_q == 2'h0 && $fell(txd_q) |-> !txd_q [*6] ##1 txd_q [*6];
    endproperty
    a_shift_clk: assert property (p_shift_clk) else $error("bad shift clock");
    property p_oe_framed;
        mode_q != 2'h0 |-> !rxd_oe_q;
    endproperty
    a_oe_framed: assert property (p_oe_framed) else $error("pin driven in framed mode");
endmodule

//--- test/testbench.sv
// Self-checking bench: register tasks on the port, peer on the lines
module testbench;
    timeunit 1ns / 1ns;
    localparam logic [31:0] CTL = 32'h0;
    localparam logic [31:0] DAT = 32'h4;
    localparam logic [31:0] CFG = 32'h3000_0380;
    localparam logic [31:0] RES = 32'h3000_0384;
    logic mclk, rst_b, wr, rd, txd_q, rxd_i, rxd_o_q, rxd_oe_q, peer_rxd, tx_irq_q, rx_irq_q;
    logic [31:0] addr, wdata, rdata_q, d, c;
    logic [8:0] got;
    logic [7:0] sh;
    logic [3:0] meter_rx;
    int fail_count, checked, m;
    // Shift-mode drive wins the shared pin
    assign rxd_i = rxd_oe_q ? rxd_o_q : peer_rxd;
    async_serial_port_autobaud i_dut (
        .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_q(rdata_q), .txd_q(txd_q), .rxd_i(rxd_i), .rxd_o_q(rxd_o_q),
        .rxd_oe_q(rxd_oe_q), .meter_rx(meter_rx), .tx_irq_q(tx_irq_q), .rx_irq_q(rx_irq_q)
    );
    serial_peer i_peer (.mclk(mclk), .txd(txd_q), .rxd(peer_rxd), .meter(meter_rx));
    // Core and port run from this one clock, as measurement needs
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Shift-mode bits are stable at each rising shift clock
    always @(posedge txd_q)
        if (rxd_oe_q === 1'b1)
            sh = {rxd_o_q, sh[7:1]};
    task automatic test_done();
        if (fail_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("MISMATCH %0t ns: saw %h, expected %h", $time, s, e);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [31:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata_q;
    endtask
    task automatic poll(input logic [31:0] a, input int b, input logic v);
        for (int n = 0; n < 400; n++)
        begin
            rd_reg(a);
            if (d[b] === v)
                return;
        end
        fail_count++;
        $display("MISMATCH %0t ns: wait ran out", $time);
        test_done();
    endtask
    initial
    begin
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        rd_reg(CTL);
        chk(d, 32'h0);
        rd_reg(CFG);
        chk(d, 32'h0);
        rd_reg(32'h8);
        chk(d, 32'h0);
        // Eight-bit frame out at one tick per clock
        wr_reg(CTL, 32'h0300_1050);
        wr_reg(DAT, 32'ha5);
        fork
            i_peer.grab(8, got);
            begin
                rd_reg(CTL);
                chk(d[23], 1'b1);
            end
        join
        chk(got, 32'ha5);
        poll(CTL, 1, 1'b1);
        chk(tx_irq_q, 1'b1);
        poll(CTL, 23, 1'b0);
        // Flag left set, so only the cleared enable keeps the request low
        wr_reg(CTL, 32'h0100_1052);
        i_peer.send(8, 9'h3c);
        poll(CTL, 0, 1'b1);
        chk(rx_irq_q, 1'b1);
        rd_reg(DAT);
        chk(d, 32'h3c);
        // Receiver off: a whole frame leaves the flag clear
        wr_reg(CTL, 32'h0000_1040);
        i_peer.send(8, 9'hff);
        rd_reg(CTL);
        chk(d[0], 1'b0);
        // Both nine-bit codes; the second filters on the ninth bit
        for (m = 2; m < 4; m++)
        begin
            c = 32'h1010 | (m << 6) | (m == 3 ? 32'h20 : 32'h08);
            wr_reg(CTL, c);
            wr_reg(DAT, 32'h5a);
            i_peer.grab(9, got);
            chk(got, {m == 2, 8'h5a});
            i_peer.send(9, 9'h096);
            rd_reg(CTL);
            chk(d[2:0], m == 2 ? 3'h3 : 3'h2);
            wr_reg(CTL, c);
            i_peer.send(9, 9'h169);
            poll(CTL, 0, 1'b1);
            chk(d[2], 1'b1);
            rd_reg(DAT);
            chk(d, 32'h69);
        end
        wr_reg(CTL, 32'h0200_0000);
        wr_reg(DAT, 32'h96);
        poll(CTL, 1, 1'b1);
        chk(sh, 32'h96);
        // Shift-mode reception clocks in the idle-high line
        wr_reg(CTL, 32'h0000_0010);
        poll(CTL, 0, 1'b1);
        chk(d[1:0], 2'h1);
        rd_reg(DAT);
        chk(d, 32'hff);
        // A pulse on an unselected line must not be timed
        for (m = 0; m < 4; m++)
        begin
            wr_reg(CFG, 32'h40 | (m << 1));
            wr_reg(CFG, 32'h140 | (m << 1));
            i_peer.pulse((m + 1) % 4, 9);
            i_peer.pulse(m, 20 + m);
            poll(CFG, 8, 1'b0);
            rd_reg(RES);
            chk(d, 20 + m);
        end
        // Start without enable is refused
        wr_reg(CFG, 32'h100);
        rd_reg(CFG);
        chk(d, 32'h0);
        wr_reg(RES, 32'h3fff);
        rd_reg(RES);
        chk(d, 32'd23);
        test_done();
    end
endmodule
bind async_serial_port_autobaud serial_port_properties i_props (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .txd_q(txd_q), .rxd_oe_q(rxd_oe_q), .tx_irq_q(tx_irq_q),
    .rx_irq_q(rx_irq_q)
);
